//--- verification/frs_array_model.sv
/*
 Behavioural flash array behind the read and status logic.
 Assumes one-cycle program and erase request pulses from the design.
*/
`timescale 1ns/1ps
module frs_array_model #(
   parameter int PROG_DLY = 16
) (
   // Clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_rst,
   // Design side
   input  wire logic [15:0] i_addr,
   input  wire logic        i_prog_req,
   input  wire logic        i_erase_req,
   input  wire logic [15:0] i_prog_addr,
   input  wire logic [15:0] i_prog_data,
   output logic      [15:0] o_array_data,
   output logic             o_array_done
);
   logic [15:0] mem_q [16];
   int          cnt_q;
   logic        ers_q;
   assign o_array_data = mem_q[i_addr[4:1]];
   // Programming only clears bits, erasing sets every bit.
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         for (int k = 0; k < 16; k++) begin
            mem_q[k] <= 16'hFFF0 | 16'(k);
         end
         cnt_q <= 0;
         ers_q <= 1'b0;
         o_array_done <= 1'b0;
      end else begin
         o_array_done <= 1'b0;
         if (i_prog_req || i_erase_req) begin
            cnt_q <= PROG_DLY;
            ers_q <= i_erase_req;
         end else if (cnt_q == 1) begin
            cnt_q <= 0;
            o_array_done <= 1'b1;
            if (ers_q) begin
               for (int k = 0; k < 16; k++) begin
                  mem_q[k] <= 16'hFFFF;
               end
            end else begin
               mem_q[i_prog_addr[4:1]] <= mem_q[i_prog_addr[4:1]] & i_prog_data;
            end
         end else if (cnt_q > 1) begin
            cnt_q <= cnt_q - 1;
         end
      end
   end
endmodule

//--- verification/test_flash_read_and_status_logic.sv
/*
 Self-checking bench for the flash read and status logic.
 Assumes the array model answers program requests after a fixed delay.
*/
`timescale 1ns/1ps
module test_flash_read_and_status_logic;
   logic        i_clock;
   logic        i_rst;
   logic [15:0] i_addr;
   logic [15:0] i_wdata;
   logic        i_write_strobe_n;
   logic        i_read;
   logic [7:0]  i_primary_sector_selects;
   logic [3:0]  i_secondary_sector_selects;
   logic        i_big_endian;
   logic [11:0] i_sector_protect;
   logic [15:0] o_rdata;
   logic        o_busy;
   logic [15:0] array_data;
   logic        array_done;
   logic        prog_req;
   logic        erase_req;
   logic [15:0] prog_addr;
   logic [15:0] prog_data;
   logic [11:0] erase_sectors;
   int          bad_count = 0;
   int          n_compared = 0;
   int          n_prog = 0;
   localparam logic [15:0] A1 = {4'h0, frs_pkg::ADDR_UNLOCK1};
   localparam logic [15:0] A2 = {4'h0, frs_pkg::ADDR_UNLOCK2};

   frs_flash_read_status #(.ERASE_WIN_CYC(20), .PROT_ERR_CYC(20), .GAP_CYC(50),
      .PROG_TOUT_CYC(40), .ERASE_CYC(30)) dut_u (
      .i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_write_strobe_n(i_write_strobe_n), .i_read(i_read),
      .i_primary_sector_selects(i_primary_sector_selects),
      .i_secondary_sector_selects(i_secondary_sector_selects),
      .i_big_endian(i_big_endian), .o_rdata(o_rdata), .o_busy(o_busy),
      .i_array_data(array_data), .i_sector_protect(i_sector_protect),
      .i_array_done(array_done), .o_prog_req(prog_req), .o_erase_req(erase_req),
      .o_erase_sectors(erase_sectors), .o_prog_addr(prog_addr), .o_prog_data(prog_data));

   frs_array_model model_u (
      .i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_prog_req(prog_req),
      .i_erase_req(erase_req), .i_prog_addr(prog_addr), .i_prog_data(prog_data),
      .o_array_data(array_data), .o_array_done(array_done));

   initial begin
      i_clock = 1'b0;
      forever #4 i_clock = ~i_clock;
   end

   always @(posedge i_clock) begin
      if (prog_req === 1'b1) n_prog++;
   end

   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      i_addr = a;
      i_wdata = d;
      i_write_strobe_n = 1'b0;
      @(negedge i_clock);
      i_write_strobe_n = 1'b1;
      @(negedge i_clock);
   endtask

   task automatic rd(input logic [15:0] a, output logic [15:0] q);
      i_addr = a;
      i_read = 1'b1;
      @(negedge i_clock);
      i_read = 1'b0;
      @(negedge i_clock);
      q = o_rdata;
   endtask

   task automatic unlock(input logic [7:0] cmd);
      wr(A1, {8'h00, frs_pkg::CMD_UNLOCK1});
      wr(A2, {8'h00, frs_pkg::CMD_UNLOCK2});
      wr(A1, {8'h00, cmd});
   endtask

   task automatic test_read_mode();
      logic [15:0] q;
      for (int k = 0; k < 4; k++) begin
         rd(16'(2 * k), q);
         chk("array word", q, 16'hFFF0 | 16'(k));
      end
   endtask

   task automatic test_id_read(input logic prim);
      logic [15:0] q;
      i_primary_sector_selects = prim ? 8'h01 : 8'h00;
      i_secondary_sector_selects = prim ? 4'h0 : 4'h1;
      unlock(frs_pkg::CMD_IDREAD);
      rd({8'h00, frs_pkg::OFS_ID}, q);
      chk("identifier", q, prim ? 16'h005A : 16'hFFF1);
      if (prim) begin
         i_sector_protect = 12'h001;
         rd({8'h00, frs_pkg::OFS_PROT}, q);
         chk("protect yes", q, {8'h00, frs_pkg::PROT_YES});
         i_sector_protect = 12'h000;
         rd({8'h00, frs_pkg::OFS_PROT}, q);
         chk("protect no", q, {8'h00, frs_pkg::PROT_NO});
      end
      wr(16'h0000, {8'h00, frs_pkg::CMD_RESET});
      rd({8'h00, frs_pkg::OFS_ID}, q);
      chk("after reset", q, 16'hFFF1);
      i_primary_sector_selects = 8'h01;
      i_secondary_sector_selects = 4'h0;
   endtask

   task automatic test_program(input logic be, input logic prot, input int idx);
      logic [15:0] s1;
      logic [15:0] s2;
      logic [15:0] d;
      int          n0;
      int          p;
      d = 16'h5A30;
      n0 = n_prog;
      p = be ? 8 : 0;
      i_big_endian = be;
      i_sector_protect = {11'h000, prot};
      unlock(frs_pkg::CMD_PROGRAM);
      wr(16'(2 * idx), d);
      @(negedge i_clock);
      chk("prog requests", 16'(n_prog - n0), prot ? 16'h0000 : 16'h0001);
      if (!prot) begin
         rd(16'(2 * idx), s1);
         rd(16'(2 * idx), s2);
         chk("poll bit", 16'(s1[p + 7]), {15'h0000, ~d[7]});
         chk("toggle flips", 16'(s1[p + 6] ^ s2[p + 6]), 16'h0001);
         chk("no error", 16'(s1[p + 5]), 16'h0000);
         for (int w = 0; w < 100 && o_busy !== 1'b0; w++) @(negedge i_clock);
      end
      rd(16'(2 * idx), s1);
      rd(16'(2 * idx), s2);
      chk("stored word", s1, prot ? 16'hFFF0 | 16'(idx) : d & (16'hFFF0 | 16'(idx)));
      chk("stable reads", s2, s1);
      i_sector_protect = 12'h000;
      i_big_endian = 1'b0;
   endtask

   task automatic test_gap_abort();
      logic [15:0] q;
      wr(A1, {8'h00, frs_pkg::CMD_UNLOCK1});
      repeat (60) @(negedge i_clock);
      wr(A2, {8'h00, frs_pkg::CMD_UNLOCK2});
      wr(A1, {8'h00, frs_pkg::CMD_IDREAD});
      rd({8'h00, frs_pkg::OFS_ID}, q);
      chk("gap abort", q, 16'hFFF1);
   endtask

   task automatic test_prog_error();
      logic [15:0] q;
      unlock(frs_pkg::CMD_PROGRAM);
      wr(16'h000C, 16'hFFFF);
      @(negedge i_clock);
      rd(16'h000C, q);
      chk("error set", {15'h0000, q[frs_pkg::BIT_ERROR]}, 16'h0001);
      wr(16'h0001, {8'h00, frs_pkg::CMD_RESET});
      rd(16'h000C, q);
      chk("error held", {15'h0000, q[frs_pkg::BIT_ERROR]}, 16'h0001);
      wr(16'h0000, {8'h00, frs_pkg::CMD_RESET});
      rd(16'h000C, q);
      chk("error cleared", q, 16'h5A30);
   endtask

   task automatic test_sector_erase(input logic prot);
      logic [15:0] q;
      logic [15:0] s1;
      logic [15:0] s2;
      i_sector_protect = prot ? 12'h003 : 12'h000;
      unlock(frs_pkg::CMD_ERASE_SET);
      wr(A1, {8'h00, frs_pkg::CMD_UNLOCK1});
      wr(A2, {8'h00, frs_pkg::CMD_UNLOCK2});
      wr(16'h0000, {8'h00, frs_pkg::CMD_SECT_ERASE});
      rd(16'h0000, q);
      chk("window open", {15'h0000, q[frs_pkg::BIT_EWIN]}, 16'h0000);
      i_primary_sector_selects = 8'h02;
      wr(16'h0000, {8'h00, frs_pkg::CMD_SECT_ERASE});
      i_primary_sector_selects = 8'h01;
      repeat (22) @(negedge i_clock);
      rd(16'h0000, s1);
      rd(16'h0000, s2);
      chk("window closed", {15'h0000, s1[frs_pkg::BIT_EWIN]}, 16'h0001);
      chk("erase poll", {15'h0000, s1[frs_pkg::BIT_POLL]}, 16'h0000);
      chk("erase toggle", {14'h0000, s1[6], s2[6]}, prot ? 16'h0000 : 16'h0002);
      for (int w = 0; w < 100 && o_busy !== 1'b0; w++) @(negedge i_clock);
      rd(16'h0000, q);
      chk("after erase", q, prot ? 16'hFFF0 : 16'hFFFF);
      chk("erase sectors", {4'h0, erase_sectors}, 16'h0003);
      i_sector_protect = 12'h000;
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      #20000;
      bad_count++;
      print_verdict();
   end

   initial begin
      i_rst = 1'b1;
      i_addr = 16'h0000;
      i_wdata = 16'h0000;
      i_write_strobe_n = 1'b1;
      i_read = 1'b0;
      i_primary_sector_selects = 8'h00;
      i_secondary_sector_selects = 4'h0;
      i_big_endian = 1'b0;
      i_sector_protect = 12'h000;
      repeat (16) @(negedge i_clock);
      i_rst = 1'b0;
      i_primary_sector_selects = 8'h01;
      test_read_mode();
      test_id_read(1'b1);
      test_id_read(1'b0);
      test_program(1'b0, 1'b0, 6);
      test_program(1'b1, 1'b0, 7);
      test_program(1'b0, 1'b1, 3);
      test_gap_abort();
      test_prog_error();
      test_sector_erase(1'b1);
      test_sector_erase(1'b0);
      print_verdict();
   end
endmodule

//--- verilog/frs_flash_read_status.sv
/*
 Read side, instruction decoder and status word of one dual-bank embedded flash.
 Assumes host bus signals synchronous to i_clock, a single-cycle write strobe
 rising edge as end of a write, and an external array model on the memory ports.
*/
`timescale 1ns/1ps
// Summary of operation
// - After power-up the decoder sits in array read mode.
// - Chip reset or reset instruction puts both arrays in read mode.
// - Identifier read is three writes followed by one read.
// - Secondary array never answers the identifier instruction.
// - Protection read returns 01h when protected and 00h otherwise.
// - Status lives in the low byte: poll 7, toggle 6, error 5, window 3.
// - Big-endian mode moves status to bits 15, 14, 13 and 11.
// - Remaining status bits carry no guaranteed value; they read zero here.
// - Poll bit is inverted data during program, true data after.
// - Poll and toggle valid after fourth or sixth write at the target.
// - Poll bit reads zero while erasing, stored data after.
// - Program into a protected sector is ignored.
// - Erase of only protected sectors: poll reads zero about 100 us.
// - Toggle bit inverts on every read while busy with a select active.
// - Toggling stops at completion and reads return array data.
// - Erase of only protected sectors: toggle reads zero about 100 us.
// - Error bit is zero normally, one on a failed program or erase.
// - Error on a zero to one program or a program timeout.
// - Error bit is cleared only by the reset instruction.
// - Erase window bit reads zero for the window, restarted by each erase command.
// - Instructions open with AAh at AAAh and 55h at 554h; 90h is id read.
// - Invalid sequence or too long a byte gap returns to read mode.
// - Reset instruction is F0h to any even address and leaves special modes.
// - Decode uses address bits 11 to 0; id at 02h, protection at 04h.
module frs_flash_read_status #(
   parameter int ERASE_WIN_CYC = frs_pkg::ERASE_WIN_CYC,
   parameter int PROT_ERR_CYC  = frs_pkg::PROT_ERR_CYC,
   parameter int GAP_CYC       = frs_pkg::GAP_CYC,
   parameter int PROG_TOUT_CYC = frs_pkg::PROG_TOUT_CYC,
   parameter int ERASE_CYC     = frs_pkg::ERASE_CYC,
   // Arbitrary identifier value, chosen only to be recognisable.
   parameter logic [7:0] ID_CODE = 8'h5A
) (
   // Clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_rst,
   // Host bus
   input  wire logic [15:0] i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_write_strobe_n,
   input  wire logic        i_read,
   input  wire logic [7:0]  i_primary_sector_selects,
   input  wire logic [3:0]  i_secondary_sector_selects,
   input  wire logic        i_big_endian,
   output logic      [15:0] o_rdata,
   output logic             o_busy,
   // Array side
   input  wire logic [15:0] i_array_data,
   input  wire logic [11:0] i_sector_protect,
   input  wire logic        i_array_done,
   output logic             o_prog_req,
   output logic             o_erase_req,
   output logic      [11:0] o_erase_sectors,
   output logic      [15:0] o_prog_addr,
   output logic      [15:0] o_prog_data
);
   typedef enum logic [3:0] {
      FRS_READ  = 4'h0, FRS_U1 = 4'h1, FRS_U2 = 4'h2, FRS_ID = 4'h3,
      FRS_PGM   = 4'h4, FRS_E3 = 4'h5, FRS_E4 = 4'h6, FRS_E5 = 4'h7,
      FRS_EWIN  = 4'h8, FRS_BUSYP = 4'h9, FRS_BUSYE = 4'hA, FRS_PROTE = 4'hB,
      FRS_ERR   = 4'hC
   } frs_state_e;

   frs_state_e  state_q;
   logic        strobe_prev_q;
   logic        toggle_q;
   logic        secondary_q;
   logic [11:0] sectors_q;
   logic [15:0] paddr_q;
   logic [15:0] pdata_q;
   logic [31:0] timer_q;
   logic [31:0] gap_q;
   logic [15:0] rdata_q;
   logic        prog_req_q;
   logic        erase_req_q;
   logic        bad_bits_q;

   function automatic logic [7:0] frs_status(input logic poll, input logic tog,
                                             input logic err, input logic ewin);
      logic [7:0] s;
      s = 8'h00;
      s[frs_pkg::BIT_POLL]   = poll;
      s[frs_pkg::BIT_TOGGLE] = tog;
      s[frs_pkg::BIT_ERROR]  = err;
      s[frs_pkg::BIT_EWIN]   = ewin;
      return s;
   endfunction

   wire logic [11:0] sel_vec  = {i_secondary_sector_selects, i_primary_sector_selects};
   wire logic        any_sel  = |sel_vec;
   wire logic        sec_sel  = |i_secondary_sector_selects;
   wire logic        wr_done  = i_write_strobe_n & ~strobe_prev_q & any_sel;
   wire logic [11:0] a12      = i_addr[11:0];
   wire logic [7:0]  wb       = i_wdata[7:0];
   wire logic        prot_hit = |(sel_vec & i_sector_protect);
   wire logic        busy     = (state_q == FRS_BUSYP) | (state_q == FRS_BUSYE) |
                                (state_q == FRS_PROTE) | (state_q == FRS_EWIN);
   wire logic        same_arr = (sec_sel == secondary_q);
   wire logic        err_st   = (state_q == FRS_ERR);
   wire logic        zero_one = bad_bits_q;

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         strobe_prev_q <= 1'b1;
      end else begin
         strobe_prev_q <= i_write_strobe_n;
      end
   end

   // Instruction decoder and algorithm sequencing.
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         state_q     <= FRS_READ;
         secondary_q <= 1'b0;
         sectors_q   <= 12'h000;
         paddr_q     <= 16'h0000;
         pdata_q     <= 16'h0000;
         timer_q     <= 32'h0000_0000;
         gap_q       <= 32'h0000_0000;
         prog_req_q  <= 1'b0;
         erase_req_q <= 1'b0;
         bad_bits_q  <= 1'b0;
      end else begin
         prog_req_q  <= 1'b0;
         erase_req_q <= 1'b0;
         if (timer_q != 32'h0000_0000) begin
            timer_q <= timer_q - 32'h0000_0001;
         end
         if (wr_done) begin
            gap_q <= 32'h0000_0000;
         end else if (gap_q != 32'hFFFF_FFFF) begin
            gap_q <= gap_q + 32'h0000_0001;
         end
         case (state_q)
            FRS_READ: begin
               if (wr_done && wb == frs_pkg::CMD_UNLOCK1 && a12 == frs_pkg::ADDR_UNLOCK1) begin
                  state_q     <= FRS_U1;
                  secondary_q <= sec_sel;
               end
            end
            FRS_U1, FRS_U2, FRS_PGM, FRS_E3, FRS_E4, FRS_E5: begin
               if (gap_q > 32'(GAP_CYC) && !wr_done) begin
                  state_q <= FRS_READ;
               end else if (wr_done) begin
                  state_q <= FRS_READ;
                  if (state_q != FRS_PGM && wb == frs_pkg::CMD_RESET && !i_addr[0]) begin
                     state_q <= FRS_READ;
                  end else if (state_q == FRS_U1 && wb == frs_pkg::CMD_UNLOCK2 &&
                               a12 == frs_pkg::ADDR_UNLOCK2) begin
                     state_q <= FRS_U2;
                  end else if (state_q == FRS_U2 && a12 == frs_pkg::ADDR_UNLOCK1) begin
                     if (wb == frs_pkg::CMD_IDREAD) begin
                        state_q <= FRS_ID;
                     end else if (wb == frs_pkg::CMD_PROGRAM) begin
                        state_q <= FRS_PGM;
                     end else if (wb == frs_pkg::CMD_ERASE_SET) begin
                        state_q <= FRS_E3;
                     end
                  end else if (state_q == FRS_PGM) begin
                     paddr_q <= i_addr;
                     pdata_q <= i_wdata;
                     bad_bits_q <= |(i_wdata & ~i_array_data);
                     if (prot_hit) begin
                        state_q <= FRS_READ;
                     end else begin
                        state_q    <= FRS_BUSYP;
                        prog_req_q <= 1'b1;
                        timer_q    <= 32'(PROG_TOUT_CYC);
                     end
                  end else if (state_q == FRS_E3 && wb == frs_pkg::CMD_UNLOCK1 &&
                               a12 == frs_pkg::ADDR_UNLOCK1) begin
                     state_q <= FRS_E4;
                  end else if (state_q == FRS_E4 && wb == frs_pkg::CMD_UNLOCK2 &&
                               a12 == frs_pkg::ADDR_UNLOCK2) begin
                     state_q <= FRS_E5;
                  end else if (state_q == FRS_E5 && wb == frs_pkg::CMD_SECT_ERASE) begin
                     state_q   <= FRS_EWIN;
                     sectors_q <= sel_vec;
                     timer_q   <= 32'(ERASE_WIN_CYC);
                  end else if (state_q == FRS_E5 && wb == frs_pkg::CMD_BULK_ERASE) begin
                     sectors_q <= ~i_sector_protect;
                     if (&i_sector_protect) begin
                        state_q <= FRS_PROTE;
                        timer_q <= 32'(PROT_ERR_CYC);
                     end else begin
                        state_q     <= FRS_BUSYE;
                        erase_req_q <= 1'b1;
                        timer_q     <= 32'(ERASE_CYC);
                     end
                  end
               end
            end
            FRS_ID: begin
               if (wr_done && wb == frs_pkg::CMD_RESET && !i_addr[0]) begin
                  state_q <= FRS_READ;
               end
            end
            FRS_EWIN: begin
               if (wr_done && wb == frs_pkg::CMD_SECT_ERASE) begin
                  sectors_q <= sectors_q | sel_vec;
                  timer_q   <= 32'(ERASE_WIN_CYC);
               end else if (wr_done) begin
                  state_q <= FRS_READ;
               end else if (timer_q == 32'h0000_0000) begin
                  if ((sectors_q & ~i_sector_protect) == 12'h000) begin
                     state_q <= FRS_PROTE;
                     timer_q <= 32'(PROT_ERR_CYC);
                  end else begin
                     sectors_q   <= sectors_q & ~i_sector_protect;
                     state_q     <= FRS_BUSYE;
                     erase_req_q <= 1'b1;
                     timer_q     <= 32'(ERASE_CYC);
                  end
               end
            end
            FRS_BUSYP: begin
               if (zero_one || (timer_q == 32'h0000_0000 && !i_array_done)) begin
                  state_q <= FRS_ERR;
               end else if (i_array_done) begin
                  state_q <= FRS_READ;
               end
            end
            FRS_BUSYE: begin
               if (timer_q == 32'h0000_0000 && !i_array_done) begin
                  state_q <= FRS_ERR;
               end else if (i_array_done) begin
                  state_q <= FRS_READ;
               end
            end
            FRS_PROTE: begin
               if (timer_q == 32'h0000_0000) begin
                  state_q <= FRS_READ;
               end
            end
            FRS_ERR: begin
               if (wr_done && wb == frs_pkg::CMD_RESET && !i_addr[0]) begin
                  state_q <= FRS_READ;
               end
            end
            default: state_q <= FRS_READ;
         endcase
      end
   end

   // Toggle bit flips on each selected read while busy or in error, except in FRS_PROTE.
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         toggle_q <= 1'b0;
      end else if (!busy && !err_st) begin
         toggle_q <= 1'b0;
      end else if (i_read && any_sel && state_q != FRS_PROTE) begin
         toggle_q <= ~toggle_q;
      end
   end

   // Read data path.
   wire logic       poll_now = (state_q == FRS_BUSYP) ?
                               ~pdata_q[frs_pkg::BIT_POLL] : 1'b0;
   wire logic [7:0] st_byte  = frs_status(poll_now, (state_q == FRS_PROTE) ? 1'b0 : toggle_q,
                                          err_st, state_q != FRS_EWIN);

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         rdata_q <= 16'h0000;
      end else if (i_read) begin
         if ((busy || err_st) && same_arr && any_sel) begin
            rdata_q <= i_big_endian ? {st_byte, 8'h00} : {8'h00, st_byte};
         end else if (state_q == FRS_ID && a12[7:0] == frs_pkg::OFS_ID) begin
            rdata_q <= secondary_q ? i_array_data : {8'h00, ID_CODE};
         end else if (state_q == FRS_ID && a12[7:0] == frs_pkg::OFS_PROT) begin
            rdata_q <= {8'h00, prot_hit ? frs_pkg::PROT_YES : frs_pkg::PROT_NO};
         end else begin
            rdata_q <= i_array_data;
         end
      end
   end

   assign o_rdata         = rdata_q;
   assign o_prog_req      = prog_req_q;
   assign o_erase_req     = erase_req_q;
   assign o_erase_sectors = sectors_q;
   assign o_prog_addr     = paddr_q;
   assign o_prog_data     = pdata_q;

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_busy <= 1'b0;
      end else begin
         o_busy <= busy;
      end
   end

   a_reset_read: assert property (@(posedge i_clock) $fell(i_rst) |-> state_q == FRS_READ)
      else $error("not in read mode after reset");
   a_prot_ignore: assert property (@(posedge i_clock) disable iff (i_rst)
      (state_q == FRS_PGM && wr_done && prot_hit) |=> !prog_req_q)
      else $error("protected program not ignored");
   a_err_hold: assert property (@(posedge i_clock) disable iff (i_rst)
      (err_st && !(wr_done && wb == frs_pkg::CMD_RESET)) |=> err_st)
      else $error("error left without reset");
   a_ewin_restart: assert property (@(posedge i_clock) disable iff (i_rst)
      (state_q == FRS_EWIN && wr_done && wb == frs_pkg::CMD_SECT_ERASE)
      |=> timer_q == 32'(ERASE_WIN_CYC))
      else $error("erase window not restarted");
   a_toggle_flip: assert property (@(posedge i_clock) disable iff (i_rst)
      (state_q == FRS_BUSYP && $past(state_q) == FRS_BUSYP && i_read && any_sel)
      |=> toggle_q != $past(toggle_q))
      else $error("toggle did not invert");
   a_id_sec: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_read && state_q == FRS_ID && secondary_q && !busy) |=> o_rdata == $past(i_array_data))
      else $error("secondary answered identifier");
   a_prog_start: assert property (@(posedge i_clock) disable iff (i_rst)
      (state_q == FRS_PGM && wr_done && !prot_hit && wb != frs_pkg::CMD_RESET)
      |=> prog_req_q && state_q == FRS_BUSYP)
      else $error("program not started");
   a_zero_one: assert property (@(posedge i_clock) disable iff (i_rst)
      (state_q == FRS_BUSYP && zero_one) |=> err_st)
      else $error("zero to one not flagged");

   sequence frs_window_expiry_s;
      state_q == FRS_EWIN && timer_q == 32'h0000_0000 && !wr_done;
   endsequence
   a_erase_launch: assert property (@(posedge i_clock) disable iff (i_rst)
      frs_window_expiry_s |=> (state_q == FRS_BUSYE || state_q == FRS_PROTE))
      else $error("erase window expiry not handled");
   a_prot_status: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_read && state_q == FRS_PROTE && same_arr && any_sel)
      |=> (o_rdata & 16'hC0C0) == 16'h0000)
      else $error("protected erase status not zero");
   a_err_flag: assert property (@(posedge i_clock) disable iff (i_rst)
      (i_read && err_st && same_arr && any_sel) |=> (o_rdata & 16'h2020) != 16'h0000)
      else $error("error bit not shown");
   a_gap_abort: assert property (@(posedge i_clock) disable iff (i_rst)
      (state_q == FRS_U1 && gap_q > 32'(GAP_CYC) && !wr_done) |=> state_q == FRS_READ)
      else $error("byte gap did not abort");
endmodule

//--- verilog/frs_pkg.sv
/*
 Package for the flash read and status logic: instruction codes, address offsets,
 status bit positions and timing counts.
 Assumes a 125 MHz system clock.
*/
package frs_pkg;
   localparam int          CLK_MHZ        = 125;
   localparam int          ERASE_WIN_US   = 120;
   localparam int          ERASE_WIN_CYC  = ERASE_WIN_US * CLK_MHZ;
   localparam int          PROT_ERR_US    = 100;
   localparam int          PROT_ERR_CYC   = PROT_ERR_US * CLK_MHZ;
   localparam int          GAP_US         = 80;
   localparam int          GAP_CYC        = GAP_US * CLK_MHZ;
   localparam int          PROG_TOUT_US   = 400;
   localparam int          PROG_TOUT_CYC  = PROG_TOUT_US * CLK_MHZ;
   localparam int          ERASE_US       = 1000;
   localparam int          ERASE_CYC      = ERASE_US * CLK_MHZ;
   localparam logic [7:0]  CMD_UNLOCK1    = 8'hAA;
   localparam logic [7:0]  CMD_UNLOCK2    = 8'h55;
   localparam logic [7:0]  CMD_IDREAD     = 8'h90;
   localparam logic [7:0]  CMD_PROGRAM    = 8'hA0;
   localparam logic [7:0]  CMD_ERASE_SET  = 8'h80;
   localparam logic [7:0]  CMD_SECT_ERASE = 8'h30;
   localparam logic [7:0]  CMD_BULK_ERASE = 8'h10;
   localparam logic [7:0]  CMD_RESET      = 8'hF0;
   localparam logic [11:0] ADDR_UNLOCK1   = 12'hAAA;
   localparam logic [11:0] ADDR_UNLOCK2   = 12'h554;
   localparam logic [7:0]  OFS_ID         = 8'h02;
   localparam logic [7:0]  OFS_PROT       = 8'h04;
   localparam logic [7:0]  PROT_YES       = 8'h01;
   localparam logic [7:0]  PROT_NO        = 8'h00;
   localparam int          BIT_POLL       = 7;
   localparam int          BIT_TOGGLE     = 6;
   localparam int          BIT_ERROR      = 5;
   localparam int          BIT_EWIN       = 3;
   localparam int          HI_OFS         = 8;
   localparam int          ADDR_W         = 16;
endpackage
